// *** dv/mtc_pins.sv ***
// far-side model of the two timer channel pins: an external level source
// assumes the timer drives a pin only while its active-low enable is low
`timescale 1ns/1ps

module mtc_pins (
    input wire hclk,
    input wire [1:0] ch_out,
    input wire [1:0] ch_out_en_n,
    output wire [1:0] ch_in
);
    // ----------------------------------------
    // pin resolution
    // ----------------------------------------
    logic [1:0] src_r = 2'h0;
    // the timer wins where it drives; elsewhere the external source sets the wire
    assign ch_in = (~ch_out_en_n & ch_out) | (ch_out_en_n & src_r);

    // levels move just after an edge, as a signal synchronous to hclk would
    task automatic drive(input int ch, input logic lvl);
        @(posedge hclk);
        src_r[ch] <= lvl;
    endtask
endmodule // mtc_pins

// *** dv/mtc_timer_chk.sv ***
// port-level checker for the modulo timer
// assumes it is bound to mtc_timer and sees only that module's ports
`timescale 1ns/1ps

module mtc_timer_chk (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire [1:0] ch_in,
    input wire [1:0] ch_out,
    input wire [1:0] ch_out_en_n,
    input wire overflow_irq,
    input wire [1:0] channel_irq
);
    // ----------------------------------------
    // accepted address phases
    // ----------------------------------------
    wire take = hsel & htrans[1] & hready;
    wire rd_a = take & ~hwrite;
    wire wr_a = take & hwrite;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ----------------------------------------
    // properties
    // ----------------------------------------
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("slave not ready or not okay");
    a_reset_quiet: assert property ($rose(hresetn) |-> ch_out_en_n == 2'h3 && !overflow_irq
        && channel_irq == 2'h0) else $error("outputs active after reset");
    a_status_read: assert property (rd_a && haddr[7:0] == 8'h00 |=> hrdata[31:8] == 24'h0
        && !hrdata[4]) else $error("status read shows reset bit or upper bits");
    a_byte_count: assert property (rd_a && (haddr[7:0] == 8'h04 || haddr[7:0] == 8'h08)
        |=> hrdata[31:8] == 24'h0) else $error("count byte wider than 8 bits");
    a_unmapped_zero: assert property (rd_a && haddr[7:0] > 8'h1C |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!rd_a |=> $stable(hrdata))
        else $error("read data moved without a read");
    // a clearing write lands one edge after its address phase and the request
    // follows one edge later, so both earlier address phases excuse a drop
    a_chirq_sticky: assert property (channel_irq[0] && !$past(wr_a) && !$past(wr_a, 2)
        |=> channel_irq[0]) else $error("channel request dropped without a write");
    a_ovf_sticky: assert property (overflow_irq && !$past(wr_a) && !$past(wr_a, 2)
        |=> overflow_irq) else $error("overflow request dropped without a write");
    a_pin_driven: assert property (!$stable(ch_out) |-> (ch_out_en_n & $past(ch_out_en_n)
        & ($past(ch_out) ^ ch_out)) == 2'h0) else $error("pin moved while undriven");

    c_overflow: cover property ($rose(overflow_irq));
    c_channel: cover property ($rose(channel_irq[0]));
    c_pin1: cover property ($rose(ch_out[1]));
endmodule // mtc_timer_chk

// *** dv/tb.sv ***
// self-checking bench for the modulo timer: bus tasks, pin stimulus, random spans
// assumes mtc_map.vh on the include path and the pin model mtc_pins
`timescale 1ns/1ps
`include "mtc_map.vh"

module tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire hready;
    wire hresp;
    wire overflow_irq;
    wire [31:0] hrdata;
    wire [1:0] ch_in;
    wire [1:0] ch_out;
    wire [1:0] ch_out_en_n;
    wire [1:0] channel_irq;
    int fail_count = 0;
    int tests_run = 0;
    int w;
    logic [31:0] q;
    logic [15:0] cnt;
    logic pin;

    always #2 hclk = ~hclk;

    mtc_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .ch_in(ch_in), .ch_out(ch_out),
        .ch_out_en_n(ch_out_en_n), .overflow_irq(overflow_irq), .channel_irq(channel_irq));
    mtc_pins pins (.hclk(hclk), .ch_out(ch_out), .ch_out_en_n(ch_out_en_n), .ch_in(ch_in));

    // ----------------------------------------
    // tasks and expectations
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one single word transfer; the wait loops are cut only by the watchdog
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd_count();
        bus(1'b0, `MTC_COUNT_HIGH_OFS, 32'h0);
        cnt[15:8] = q[7:0];
        bus(1'b0, `MTC_COUNT_LOW_OFS, 32'h0);
        cnt[7:0] = q[7:0];
    endtask
    // checked once at the call, then on falling edges, so later reads never fall in a request's launching time step
    task automatic wait_irq(input int b);
        int n;
        n = 0;
        while ((b == 2 ? overflow_irq : channel_irq[b]) !== 1'b1 && n < 2000) begin
            @(negedge hclk);
            n++;
        end
    endtask
    function automatic logic in_window(input logic [15:0] v, input int e, input int tol);
        return (int'(v) >= e - tol) && (int'(v) <= e + tol);
    endfunction
    function automatic int exp_cnt(input int ps, input int cyc);
        return (ps == 7) ? 0 : cyc >> ps;
    endfunction
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        w = $urandom(32'h97f9);
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, `MTC_STATUS_CTRL_OFS, 32'h0);
        check("status reset", q, 32'h20);
        bus(1'b0, `MTC_MODULO_OFS, 32'h0);
        check("modulo reset", q, 32'hFFFF);
        bus(1'b0, 8'h20, 32'h0);
        check("unmapped", q, 32'h0);
        // every prescaler code, random run spans
        for (int ps = 0; ps < 8; ps++) begin
            w = 64 + ($urandom % 200);
            bus(1'b1, `MTC_STATUS_CTRL_OFS, 32'h30 | ps);
            rd_count();
            check("stop with reset", cnt, 16'h0);
            bus(1'b1, `MTC_STATUS_CTRL_OFS, 32'h10 | ps);
            repeat (w) @(posedge hclk);
            bus(1'b1, `MTC_STATUS_CTRL_OFS, 32'h20 | ps);
            rd_count();
            check("prescaled count", in_window(cnt, exp_cnt(ps, w + 3), 2), 1'b1);
            bus(1'b0, `MTC_STATUS_CTRL_OFS, 32'h0);
            check("status readback", q, 32'h20 | ps);
        end
        // a second high read must not refresh the latched low byte
        bus(1'b1, `MTC_STATUS_CTRL_OFS, 32'h10);
        bus(1'b0, `MTC_COUNT_HIGH_OFS, 32'h0);
        cnt[15:8] = q[7:0];
        repeat (8) @(posedge hclk);
        bus(1'b0, `MTC_COUNT_HIGH_OFS, 32'h0);
        bus(1'b0, `MTC_COUNT_LOW_OFS, 32'h0);
        cnt[7:0] = q[7:0];
        check("latched low byte", in_window(cnt, 1, 2), 1'b1);
        // compare actions set, clear, toggle on channel 0
        bus(1'b1, `MTC_STATUS_CTRL_OFS, 32'h30);
        bus(1'b1, `MTC_MODULO_OFS, 32'h100);
        pin = 1'b0;
        for (int act = 3; act >= 0; act--) begin
            w = 16 + ($urandom % 200);
            bus(1'b1, `MTC_CH0_VALUE_OFS, w);
            bus(1'b1, `MTC_CH0_CTRL_OFS, 32'h13 | (act << 2));
            bus(1'b1, `MTC_STATUS_CTRL_OFS, 32'h10);
            wait_irq(0);
            // no action leaves the pin where the previous compare put it
            pin = (act == 1) ? ~pin : ((act == 0) ? pin : (act == 3));
            check("compare pin", ch_out[0], pin);
            check("compare request", channel_irq[0], 1'b1);
            check("pin enable", ch_out_en_n[0], 1'b0);
            bus(1'b0, `MTC_CH0_CTRL_OFS, 32'h0);
            check("compare flag", q[7], 1'b1);
            bus(1'b1, `MTC_CH0_CTRL_OFS, 32'h0);
            bus(1'b1, `MTC_STATUS_CTRL_OFS, 32'h30);
            check("request cleared", channel_irq[0], 1'b0);
        end
        // compare value written below the count waits for the next period
        w = 60 + ($urandom % 100);
        bus(1'b1, `MTC_STATUS_CTRL_OFS, 32'h0);
        repeat (w) @(posedge hclk);
        bus(1'b1, `MTC_STATUS_CTRL_OFS, 32'h20);
        rd_count();
        bus(1'b1, `MTC_CH1_VALUE_OFS, cnt - 16'h1);
        bus(1'b1, `MTC_CH1_CTRL_OFS, 32'h1F);
        bus(1'b1, `MTC_STATUS_CTRL_OFS, 32'h40);
        repeat (40) @(negedge hclk);
        check("no compare behind count", channel_irq[1], 1'b0);
        wait_irq(2);
        check("overflow request", overflow_irq, 1'b1);
        wait_irq(1);
        check("compare after wrap", ch_out[1], 1'b1);
        bus(1'b1, `MTC_STATUS_CTRL_OFS, 32'h40);
        repeat (2) @(negedge hclk);
        check("overflow cleared", overflow_irq, 1'b0);
        bus(1'b1, `MTC_STATUS_CTRL_OFS, 32'h26);
        // capture on rise then fall; each new capture replaces the old value
        for (int m = 1; m < 3; m++) begin
            w = 200 + ($urandom % 400);
            pins.drive(0, m == 2);
            bus(1'b1, `MTC_CH0_CTRL_OFS, 32'h10 | m);
            pins.drive(0, m == 1);
            bus(1'b0, `MTC_CH0_CTRL_OFS, 32'h0);
            check("no capture while stopped", q[7], 1'b0);
            pins.drive(0, m == 2);
            bus(1'b1, `MTC_STATUS_CTRL_OFS, 32'h06);
            repeat (w) @(posedge hclk);
            pins.drive(0, m == 1);
            repeat (3) @(posedge hclk);
            bus(1'b0, `MTC_CH0_CTRL_OFS, 32'h0);
            check("capture flag", q[7], 1'b1);
            bus(1'b1, `MTC_CH0_CTRL_OFS, 32'h10 | m);
            bus(1'b1, `MTC_STATUS_CTRL_OFS, 32'h26);
            rd_count();
            bus(1'b0, `MTC_CH0_VALUE_OFS, 32'h0);
            check("captured count", in_window(q[15:0], cnt, 1), 1'b1);
        end
        // system reset in mid-run keeps the captured value
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        w = q[15:0];
        bus(1'b0, `MTC_CH0_VALUE_OFS, 32'h0);
        check("capture kept over reset", q[15:0], w[15:0]);
        complete_run();
    end

    // watchdog: the scenarios need well under 20,000 cycles
    initial begin
        #200000;
        fail_count++;
        complete_run();
    end
endmodule // tb

bind mtc_timer mtc_timer_chk chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ch_in(ch_in), .ch_out(ch_out),
    .ch_out_en_n(ch_out_en_n), .overflow_irq(overflow_irq), .channel_irq(channel_irq));

// *** rtl/mtc_map.vh ***
// register map, field positions, reset values and prescaler codes of the modulo timer
// assumes 32-bit word-aligned register access from an AHB-Lite slave
`ifndef MTC_MAP_VH
`define MTC_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MTC_STATUS_CTRL_OFS 8'h00
`define MTC_COUNT_HIGH_OFS 8'h04
`define MTC_COUNT_LOW_OFS 8'h08
`define MTC_MODULO_OFS 8'h0C
`define MTC_CH0_CTRL_OFS 8'h10
`define MTC_CH0_VALUE_OFS 8'h14
`define MTC_CH1_CTRL_OFS 8'h18
`define MTC_CH1_VALUE_OFS 8'h1C

// ----------------------------------------
// status and control field positions
// ----------------------------------------
`define MTC_PS_LSB 0
`define MTC_RST_BIT 4
`define MTC_STOP_BIT 5
`define MTC_OVIE_BIT 6
`define MTC_OVF_BIT 7

// ----------------------------------------
// channel control field positions
// ----------------------------------------
`define MTC_CH_MODE_LSB 0
`define MTC_CH_ACT_LSB 2
`define MTC_CH_IE_BIT 4
`define MTC_CH_FLAG_BIT 7

// ----------------------------------------
// channel modes and compare actions
// ----------------------------------------
`define MTC_MODE_OFF 2'h0
`define MTC_MODE_CAP_RISE 2'h1
`define MTC_MODE_CAP_FALL 2'h2
`define MTC_MODE_COMPARE 2'h3
`define MTC_ACT_NONE 2'h0
`define MTC_ACT_TOGGLE 2'h1
`define MTC_ACT_CLEAR 2'h2
`define MTC_ACT_SET 2'h3

// ----------------------------------------
// reset values and the unused prescaler code
// ----------------------------------------
`define MTC_PS_RESET 3'h0
`define MTC_MODULO_RESET 16'hFFFF
`define MTC_PS_UNUSED 3'h7

`endif

// *** rtl/mtc_prescaler.v ***
// prescaler producing a one-cycle count tick from the bus clock
// assumes hclk is the bus clock; clear restarts the divider from zero
`timescale 1ns/1ps

module mtc_prescaler (
    input wire hclk,
    input wire hresetn,
    input wire clear,
    input wire [2:0] select,
    output reg tick
);

`include "mtc_map.vh"

reg [5:0] div_r;

// ----------------------------------------
// divider and tick
// ----------------------------------------
// tick fires when all low bits of the divider are ones; code 0 ticks every cycle
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        div_r <= 6'h00;
        tick <= 1'b0;
    end else if (clear) begin
        div_r <= 6'h00;
        tick <= 1'b0;
    end else begin
        div_r <= div_r + 6'h01;
        case (select)
            3'h0: tick <= 1'b1;
            3'h1: tick <= (div_r[0] == 1'b1);
            3'h2: tick <= (div_r[1:0] == 2'h3);
            3'h3: tick <= (div_r[2:0] == 3'h7);
            3'h4: tick <= (div_r[3:0] == 4'hF);
            3'h5: tick <= (div_r[4:0] == 5'h1F);
            3'h6: tick <= (div_r == 6'h3F);
            default: tick <= 1'b0; // unused code stops the count
        endcase
    end
end

endmodule // mtc_prescaler

// *** rtl/mtc_timer.v ***
// modulo timer with two capture or compare channels behind an AHB-Lite slave
// assumes single-word transfers, one clock hclk, channel inputs synchronous to hclk
`timescale 1ns/1ps

// Functional notes
// - new capture overwrites channel value
// - all channels use shared 16-bit counter
// - system reset keeps captured values
// - compare match sets, clears or toggles pin
// - compare match raises enabled channel interrupt
// - channel value write takes effect immediately
// - overflow interrupt when flag set, enabled
// - stop bit holds counter; reset sets it
// - stop bit inhibits input captures
// - reset bit clears counter and prescaler
// - reset bit self-clears and reads zero
// - stop plus reset leaves counter zero
// - three-bit select, code zero undivided
// - codes one to six divide by powers
// - modulo reached sets flag, wraps to zero
// - high byte read latches low byte
module mtc_timer (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire [1:0] ch_in,
    output reg [1:0] ch_out,
    output reg [1:0] ch_out_en_n,
    output reg overflow_irq,
    output reg [1:0] channel_irq
);

`include "mtc_map.vh"

// ----------------------------------------
// state
// ----------------------------------------
reg [15:0] count_r;
reg [15:0] modulo_r;
reg [2:0] prescale_select_r;
reg counter_stop_r;
reg overflow_irq_enable_r;
reg overflow_flag_r;
reg counter_reset_r;
reg [7:0] low_latch_r;
reg low_latched_r;
reg [1:0] ch_mode_r [0:1];
reg [1:0] ch_act_r [0:1];
reg [1:0] ch_ie_r;
reg [1:0] ch_flag_r;
reg [15:0] channel_value_regs [0:1];
reg [1:0] ch_in_d_r;
reg wr_pend_r;
reg rd_pend_r;
reg [7:0] addr_r;
wire tick;
wire bus_req;
wire [1:0] cap_evt;
wire [1:0] cmp_evt;
wire wrap_evt;
reg [31:0] rdata_nxt;
integer i;

// decodes a byte offset into a channel number (bit 3 picks channel)
function ch_of;
    input [7:0] ofs;
    begin
        ch_of = ofs[3];
    end
endfunction

// channel control word as software sees it
function [31:0] ch_ctrl_word;
    input [1:0] mode;
    input [1:0] act;
    input ie;
    input flag;
    begin
        ch_ctrl_word = 32'h00000000;
        ch_ctrl_word[`MTC_CH_MODE_LSB+:2] = mode;
        ch_ctrl_word[`MTC_CH_ACT_LSB+:2] = act;
        ch_ctrl_word[`MTC_CH_IE_BIT] = ie;
        ch_ctrl_word[`MTC_CH_FLAG_BIT] = flag;
    end
endfunction

// ----------------------------------------
// prescaler
// ----------------------------------------
mtc_prescaler u_prescaler (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(counter_reset_r),
    .select(prescale_select_r),
    .tick(tick)
);

// ----------------------------------------
// AHB-Lite address phase capture
// ----------------------------------------
// zero-wait slave: every transfer completes in its data phase with OKAY
assign bus_req = hsel & htrans[1] & hready;

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wr_pend_r <= 1'b0;
        rd_pend_r <= 1'b0;
        addr_r <= 8'h00;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end else begin
        wr_pend_r <= bus_req & hwrite;
        rd_pend_r <= bus_req & ~hwrite;
        if (bus_req) begin
            addr_r <= haddr[7:0];
        end
        hreadyout <= 1'b1;
        hresp <= 1'b0;
    end
end

// ----------------------------------------
// events
// ----------------------------------------
// the counter advances only on ticks, so compares are judged against the count held before the tick advances it
assign wrap_evt = tick & ~counter_stop_r & (count_r == modulo_r);

genvar g;
generate
    for (g = 0; g < 2; g = g + 1) begin : g_evt
        // capture inhibited while stopped so stale times are not taken
        assign cap_evt[g] = ~counter_stop_r &
            (((ch_mode_r[g] == `MTC_MODE_CAP_RISE) & ch_in[g] & ~ch_in_d_r[g]) |
             ((ch_mode_r[g] == `MTC_MODE_CAP_FALL) & ~ch_in[g] & ch_in_d_r[g]));
        // exact-equal compare against the live value; a value written below
        // the count is simply missed this period
        assign cmp_evt[g] = tick & ~counter_stop_r &
            (ch_mode_r[g] == `MTC_MODE_COMPARE) &
            (count_r == channel_value_regs[g]);
    end
endgenerate

// ----------------------------------------
// counter, reset bit and status/control
// ----------------------------------------
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        count_r <= 16'h0000;
        modulo_r <= `MTC_MODULO_RESET;
        prescale_select_r <= `MTC_PS_RESET;
        counter_stop_r <= 1'b1;
        overflow_irq_enable_r <= 1'b0;
        overflow_flag_r <= 1'b0;
        counter_reset_r <= 1'b0;
    end else begin
        // counter: reset bit wins, then stop holds, then tick advances
        if (counter_reset_r) begin
            count_r <= 16'h0000;
        end else if (tick & ~counter_stop_r) begin
            if (count_r == modulo_r) begin
                count_r <= 16'h0000;
            end else begin
                count_r <= count_r + 16'h0001;
            end
        end
        // reset bit lives one cycle then clears itself
        counter_reset_r <= 1'b0;
        if (wr_pend_r && addr_r == `MTC_STATUS_CTRL_OFS) begin
            prescale_select_r <= hwdata[`MTC_PS_LSB+:3];
            counter_stop_r <= hwdata[`MTC_STOP_BIT];
            overflow_irq_enable_r <= hwdata[`MTC_OVIE_BIT];
            counter_reset_r <= hwdata[`MTC_RST_BIT];
        end
        if (wr_pend_r && addr_r == `MTC_MODULO_OFS) begin
            modulo_r <= hwdata[15:0];
        end
        // overflow flag: write 0 to clear, the set wins
        if (wrap_evt) begin
            overflow_flag_r <= 1'b1;
        end else if (wr_pend_r && addr_r == `MTC_STATUS_CTRL_OFS &&
                     !hwdata[`MTC_OVF_BIT]) begin
            overflow_flag_r <= 1'b0;
        end
    end
end

// ----------------------------------------
// counter read latch
// ----------------------------------------
// high-byte read freezes the low byte so a 16-bit time reads coherently
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        low_latch_r <= 8'h00;
        low_latched_r <= 1'b0;
    end else if (rd_pend_r && addr_r == `MTC_COUNT_HIGH_OFS) begin
        if (!low_latched_r) begin
            low_latch_r <= count_r[7:0];
            low_latched_r <= 1'b1;
        end
    end else if (rd_pend_r && addr_r == `MTC_COUNT_LOW_OFS) begin
        low_latched_r <= 1'b0;
    end
end

// ----------------------------------------
// channel control, flags and pins
// ----------------------------------------
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        for (i = 0; i < 2; i = i + 1) begin
            ch_mode_r[i] <= `MTC_MODE_OFF;
            ch_act_r[i] <= `MTC_ACT_NONE;
        end
        ch_ie_r <= 2'h0;
        ch_flag_r <= 2'h0;
        ch_in_d_r <= 2'h0;
        ch_out <= 2'h0;
        ch_out_en_n <= 2'h3;
    end else begin
        ch_in_d_r <= ch_in;
        for (i = 0; i < 2; i = i + 1) begin
            if (wr_pend_r && addr_r == (`MTC_CH0_CTRL_OFS + 8'h08 * i[7:0])) begin
                ch_mode_r[i] <= hwdata[`MTC_CH_MODE_LSB+:2];
                ch_act_r[i] <= hwdata[`MTC_CH_ACT_LSB+:2];
                ch_ie_r[i] <= hwdata[`MTC_CH_IE_BIT];
            end
            // sticky flag, write 0 clears, an event in the same cycle wins
            if (cap_evt[i] | cmp_evt[i]) begin
                ch_flag_r[i] <= 1'b1;
            end else if (wr_pend_r && addr_r == (`MTC_CH0_CTRL_OFS + 8'h08 * i[7:0]) &&
                         !hwdata[`MTC_CH_FLAG_BIT]) begin
                ch_flag_r[i] <= 1'b0;
            end
            // pin driven only in compare mode; low enable means driving
            ch_out_en_n[i] <= (ch_mode_r[i] != `MTC_MODE_COMPARE);
            if (cmp_evt[i]) begin
                case (ch_act_r[i])
                    `MTC_ACT_TOGGLE: ch_out[i] <= ~ch_out[i];
                    `MTC_ACT_CLEAR: ch_out[i] <= 1'b0;
                    `MTC_ACT_SET: ch_out[i] <= 1'b1;
                    default: ch_out[i] <= ch_out[i];
                endcase
            end
        end
    end
end

// ----------------------------------------
// channel value registers
// ----------------------------------------
// no reset branch: captured times survive a system reset
always @(posedge hclk) begin
    for (i = 0; i < 2; i = i + 1) begin
        if (cap_evt[i]) begin
            channel_value_regs[i] <= count_r;
        end else if (wr_pend_r && addr_r == (`MTC_CH0_VALUE_OFS + 8'h08 * i[7:0])) begin
            channel_value_regs[i] <= hwdata[15:0];
        end
    end
end

// ----------------------------------------
// interrupt outputs
// ----------------------------------------
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        overflow_irq <= 1'b0;
        channel_irq <= 2'h0;
    end else begin
        overflow_irq <= overflow_flag_r & overflow_irq_enable_r;
        channel_irq <= ch_flag_r & ch_ie_r;
    end
end

// ----------------------------------------
// read mux
// ----------------------------------------
always @* begin
    rdata_nxt = 32'h00000000;
    case (haddr[7:0])
        `MTC_STATUS_CTRL_OFS: begin
            rdata_nxt[`MTC_PS_LSB+:3] = prescale_select_r;
            rdata_nxt[`MTC_STOP_BIT] = counter_stop_r;
            rdata_nxt[`MTC_OVIE_BIT] = overflow_irq_enable_r;
            rdata_nxt[`MTC_OVF_BIT] = overflow_flag_r; // reset bit reads 0
        end
        `MTC_COUNT_HIGH_OFS: rdata_nxt[7:0] = count_r[15:8];
        `MTC_COUNT_LOW_OFS: rdata_nxt[7:0] = low_latched_r ? low_latch_r : count_r[7:0];
        `MTC_MODULO_OFS: rdata_nxt[15:0] = modulo_r;
        `MTC_CH0_CTRL_OFS, `MTC_CH1_CTRL_OFS:
            rdata_nxt = ch_ctrl_word(ch_mode_r[ch_of(haddr[7:0])], ch_act_r[ch_of(haddr[7:0])],
                                     ch_ie_r[ch_of(haddr[7:0])], ch_flag_r[ch_of(haddr[7:0])]);
        `MTC_CH0_VALUE_OFS, `MTC_CH1_VALUE_OFS:
            rdata_nxt[15:0] = channel_value_regs[ch_of(haddr[7:0])];
        default: rdata_nxt = 32'h00000000;
    endcase
end

// read data registered at the address phase so it stands through the data phase
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hrdata <= 32'h00000000;
    end else if (bus_req & ~hwrite) begin
        hrdata <= rdata_nxt;
    end
end

endmodule // mtc_timer
